// ===== verilog/lfs_cfg.svh
// constants of the fault and supply supervisor: offsets, field positions, timing
// assumes inclusion by bare name from the package and the design module
`ifndef LFS_CFG_SVH
`define LFS_CFG_SVH

// core clock rate
`define LFS_CLK_MHZ 100
// mismatch report hold-off after the transmit line falls, in microseconds
`define LFS_MISMATCH_US 25
// regulator short-circuit recovery time, in milliseconds
`define LFS_RETRY_MS 3
`define LFS_MISMATCH_CYC (`LFS_MISMATCH_US * `LFS_CLK_MHZ)
`define LFS_RETRY_CYC (`LFS_RETRY_MS * 1000 * `LFS_CLK_MHZ)

// register byte offsets
`define LFS_OFS_CTRL 4'h0
`define LFS_OFS_STATUS 4'h4
`define LFS_OFS_EVENT 4'h8
// control fields
`define LFS_CTRL_OPT_3V3 0
`define LFS_CTRL_ALT_THR 1
`define LFS_CTRL_RESET 2'h0
// status fields
`define LFS_ST_MISMATCH 0
`define LFS_ST_THERMAL 1
`define LFS_ST_REG_ON 2
`define LFS_ST_HOST_OFF 3
`define LFS_ST_PDOWN 4
`define LFS_ST_DRV_EN 5
`define LFS_ST_STATE_LO 8
// event fields (sticky, write one to clear)
`define LFS_EV_MISMATCH 0
`define LFS_EV_SHORT 1
`define LFS_EV_UNDERV 2
`define LFS_EV_THERMAL 3
`define LFS_EV_WIDTH 4

`endif

// ===== verilog/lfs_pkg.sv
// types shared by the fault and supply supervisor
// assumes lfs_cfg.svh is on the include path
`include "lfs_cfg.svh"

package lfs_pkg;

  // inputs that arrive from pins or analog comparators, outside the clock domain
  typedef struct packed {
    logic tx_data;          // transmit data from the host
    logic bus_line_level;   // sensed bus level, high = recessive
    logic fault_pin_in;     // level seen on the fault / tx-enable pin
    logic thermal_hot;      // overtemperature detector
    logic overload;         // regulator current limit active
    logic vreg_below_3v5;   // regulator output below 3.5 V
    logic vreg_below_2v5;   // regulator output below 2.5 V
    logic vbb_above_6v0;    // battery at or above 6.0 V
    logic vbb_above_5v75;   // battery above 5.75 V
    logic track_below_3v5;  // tracking output fell to 3.5 V
    logic track_below_4v25; // tracking output fell to 4.25 V
  } lfs_pins_t;

  // regulator sequencing states
  typedef enum logic [2:0] {
    LFS_REG_START,
    LFS_REG_ON,
    LFS_REG_UV_OFF,
    LFS_REG_SHORT_OFF,
    LFS_REG_HOT_OFF,
    LFS_REG_PDOWN
  } lfs_reg_state_t;

endpackage

// ===== verilog/lfs_supervisor.sv
// fault / transmitter-enable pin logic and regulator supervision of a bus transceiver
// assumes analog comparators and pins arrive asynchronously; powerdown request comes
// from the mode logic on core_clk; open-drain pins are resolved outside
//
// Functional notes
// - fault pin low keeps transmitter off
// - compare transmit against bus, debounced
// - mismatch valid only 25 us after fall
// - bus short or thermal pulls pin low
// - regulator not good pulls pin low
// - transmit low, bus high flags short
// - agreeing levels leave pin released
// - thermal shutdown forces pin low
// - host low on pin is transmitter-off
// - reset high while supply valid
// - reset asserted on entering powerdown
// - restart regulator at 6.0 V battery
// - alternate thresholds 4.25 V off, 5.75 on
// - start at 6.0 V; monitor off in powerdown
// - short: off, wait 3 ms, recheck
// - overtemperature with tx high, or tx and rx low, shuts regulator until cool
// - 3.3 V option trips at 2.5 V
// - bus follows transmit, receive follows bus
// - pin level selects transmitter-off or operation
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "lfs_cfg.svh"

module lfs_supervisor
  import lfs_pkg::*;
#(
  parameter int MISMATCH_CYC = `LFS_MISMATCH_CYC,
  parameter int RETRY_CYC = `LFS_RETRY_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire lfs_pins_t pins,
  input wire logic powerdown_req,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic bus_line_out,
  output logic bus_line_oe,
  output logic rx_data,
  output logic fault_or_tx_enable_pin_out,
  output logic fault_or_tx_enable_pin_oe,
  output logic supply_reset_n_out,
  output logic supply_reset_n_oe,
  output logic regulator_enable
);

  localparam int NPINS = $bits(lfs_pins_t);
  localparam int MW = $clog2(MISMATCH_CYC + 1);
  localparam int RW = $clog2(RETRY_CYC + 1);
  localparam logic [MW-1:0] MISMATCH_MAX = MW'(MISMATCH_CYC);
  localparam logic [RW-1:0] RETRY_LOAD = RW'(RETRY_CYC);

  // synchroniser stages and filtered levels
  logic [NPINS-1:0] sync_a;
  logic [NPINS-1:0] sync_b;
  logic [NPINS-1:0] sync_c;
  logic [NPINS-1:0] filt;
  lfs_pins_t in_f;

  // control and state
  logic [1:0] ctrl;
  logic [`LFS_EV_WIDTH-1:0] events;
  lfs_reg_state_t reg_state;
  lfs_reg_state_t next_reg_state;
  logic [RW-1:0] retry_cnt;
  logic [MW-1:0] mismatch_cnt;
  logic mismatch_fault;
  logic fault_drive;

  // derived conditions
  logic opt_3v3;
  logic alt_thr;
  logic vreg_trip;
  logic track_floor;
  logic restart_ok;
  logic reg_good;
  logic host_tx_off;
  logic mismatch_now;
  logic short_now;
  logic hot_reg_off;
  logic next_fault_drive;
  logic next_drv_en;
  logic drv_en;
  logic wr_ctrl;
  logic wr_event;

  // three flops per input; a new level is accepted once the last two agree,
  // so a single metastable sample never reaches the logic
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (reset) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
          filt[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pins[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
          if (sync_b[gi] == sync_c[gi]) begin
            filt[gi] <= sync_c[gi];
          end
        end
      end
    end
  endgenerate

  assign in_f = lfs_pins_t'(filt);

  // option selection from the control register
  assign opt_3v3 = ctrl[`LFS_CTRL_OPT_3V3];
  assign alt_thr = ctrl[`LFS_CTRL_ALT_THR];
  assign vreg_trip = opt_3v3 ? in_f.vreg_below_2v5 : in_f.vreg_below_3v5;
  assign track_floor = alt_thr ? in_f.track_below_4v25 : in_f.track_below_3v5;
  assign restart_ok = alt_thr ? in_f.vbb_above_5v75 : in_f.vbb_above_6v0;
  assign reg_good = (reg_state == LFS_REG_ON);
  // short seen while current limit holds the output down
  assign short_now = in_f.overload & vreg_trip;
  // overtemperature with tx and rx low, or tx high
  assign hot_reg_off = in_f.thermal_hot &
                       ((~in_f.tx_data & ~in_f.bus_line_level) | in_f.tx_data);

  // pin low while we release it means the host commands transmitter-off
  // right after our own release the synchronised level lags a few cycles
  assign host_tx_off = ~in_f.fault_pin_in & ~fault_drive;

  // transmit low while the bus stays recessive is a short to battery
  assign mismatch_now = ~in_f.tx_data & in_f.bus_line_level & ~host_tx_off;

  // the count restarts whenever agreement returns, so only a disagreement
  // that fills the whole window reports a fault
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mismatch_cnt <= '0;
      mismatch_fault <= 1'b0;
    end else if (!mismatch_now) begin
      mismatch_cnt <= '0;
      mismatch_fault <= 1'b0;
    end else if (mismatch_cnt == MISMATCH_MAX) begin
      // window of 25 us after the transmit fall
      mismatch_fault <= 1'b1;
    end else begin
      mismatch_cnt <= mismatch_cnt + MW'(1);
    end
  end

  // regulator sequencing: start, tracking cut-off, short retry, thermal and powerdown
  always_comb begin
    next_reg_state = reg_state;
    case (reg_state)
      LFS_REG_START: begin
        // operation starts only at 6.0 V
        if (in_f.vbb_above_6v0) begin
          next_reg_state = LFS_REG_ON;
        end
      end
      LFS_REG_ON: begin
        if (hot_reg_off) begin
          next_reg_state = LFS_REG_HOT_OFF;
        end else if (short_now) begin
          next_reg_state = LFS_REG_SHORT_OFF;
        end else if (track_floor && !in_f.overload) begin
          next_reg_state = LFS_REG_UV_OFF;
        end
      end
      LFS_REG_UV_OFF: begin
        if (restart_ok) begin
          next_reg_state = LFS_REG_ON;
        end
      end
      LFS_REG_SHORT_OFF: begin
        if (retry_cnt == '0 && !vreg_trip) begin
          next_reg_state = LFS_REG_ON;
        end
      end
      LFS_REG_HOT_OFF: begin
        if (!in_f.thermal_hot) begin
          next_reg_state = LFS_REG_ON;
        end
      end
      LFS_REG_PDOWN: begin
        next_reg_state = LFS_REG_START;
      end
      default: begin
        next_reg_state = LFS_REG_START;
      end
    endcase
    // powerdown overrides everything and keeps the monitor off
    if (powerdown_req) begin
      next_reg_state = LFS_REG_PDOWN;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_state <= LFS_REG_START;
    end else begin
      reg_state <= next_reg_state;
    end
  end

  // recovery timer, reloaded each time the short is still present
  always_ff @(posedge core_clk) begin
    if (reset) begin
      retry_cnt <= '0;
    end else if (next_reg_state == LFS_REG_SHORT_OFF &&
                 (reg_state != LFS_REG_SHORT_OFF || retry_cnt == '0)) begin
      retry_cnt <= RETRY_LOAD;
    end else if (retry_cnt != '0) begin
      retry_cnt <= retry_cnt - RW'(1);
    end
  end

  // fault sources that pull the shared pin low
  always_comb begin
    // thermal shutdown regardless of tx and rx
    next_fault_drive = mismatch_fault | in_f.thermal_hot | (next_reg_state != LFS_REG_ON);
    // a low pin, ours or the host's, disables the driver
    // a high pin returns to operation
    next_drv_en = ~next_fault_drive & in_f.fault_pin_in;
  end

  // pin, driver and regulator outputs, all registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fault_drive <= 1'b1;
      drv_en <= 1'b0;
      fault_or_tx_enable_pin_out <= 1'b0;
      fault_or_tx_enable_pin_oe <= 1'b1;
      bus_line_out <= 1'b0;
      bus_line_oe <= 1'b0;
      rx_data <= 1'b1;
      regulator_enable <= 1'b0;
    end else begin
      fault_drive <= next_fault_drive;
      drv_en <= next_drv_en;
      // released (pin high) unless a fault pulls it low
      fault_or_tx_enable_pin_out <= 1'b0;
      fault_or_tx_enable_pin_oe <= next_fault_drive;
      // dominant only for transmit low with the driver enabled
      bus_line_out <= 1'b0;
      bus_line_oe <= next_drv_en & ~in_f.tx_data;
      rx_data <= in_f.bus_line_level;
      regulator_enable <= (next_reg_state == LFS_REG_ON);
    end
  end

  // supply reset pin: open drain, low while the supply is not valid
  always_ff @(posedge core_clk) begin
    if (reset) begin
      supply_reset_n_out <= 1'b0;
      supply_reset_n_oe <= 1'b1;
    end else begin
      supply_reset_n_out <= 1'b0;
      // held high only while the regulator is good
      supply_reset_n_oe <= (next_reg_state != LFS_REG_ON) | powerdown_req;
    end
  end

  // register decode
  assign wr_ctrl = reg_wr && (reg_addr == `LFS_OFS_CTRL);
  assign wr_event = reg_wr && (reg_addr == `LFS_OFS_EVENT);

  // control register steers the trip and restart thresholds
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl <= `LFS_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata[1:0];
    end
  end

  // sticky events; a new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      events <= '0;
    end else begin
      events <= (events & ~(wr_event ? reg_wdata[`LFS_EV_WIDTH-1:0] : '0)) |
                {in_f.thermal_hot,
                 (reg_state == LFS_REG_ON && next_reg_state == LFS_REG_UV_OFF),
                 (reg_state == LFS_REG_ON && next_reg_state == LFS_REG_SHORT_OFF),
                 mismatch_fault};
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `LFS_OFS_CTRL: begin
            reg_rdata[1:0] <= ctrl;
          end
          `LFS_OFS_STATUS: begin
            reg_rdata[`LFS_ST_MISMATCH] <= mismatch_fault;
            reg_rdata[`LFS_ST_THERMAL] <= in_f.thermal_hot;
            reg_rdata[`LFS_ST_REG_ON] <= reg_good;
            reg_rdata[`LFS_ST_HOST_OFF] <= host_tx_off;
            reg_rdata[`LFS_ST_PDOWN] <= (reg_state == LFS_REG_PDOWN);
            reg_rdata[`LFS_ST_DRV_EN] <= drv_en;
            reg_rdata[`LFS_ST_STATE_LO +: 3] <= reg_state;
          end
          `LFS_OFS_EVENT: begin
            reg_rdata[`LFS_EV_WIDTH-1:0] <= events;
          end
          default: begin
            reg_rdata <= '0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== bench/lfs_supervisor_asserts.sv
// checker for the supervisor's pin, reset, bus and regulator outputs
// assumes it is bound into lfs_supervisor and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module lfs_supervisor_asserts
  import lfs_pkg::*;
#(
  parameter int MISMATCH_CYC = 20,
  parameter int RETRY_CYC = 50
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire lfs_pins_t pins,
  input wire logic powerdown_req,
  input wire logic bus_line_oe,
  input wire logic fault_or_tx_enable_pin_oe,
  input wire logic supply_reset_n_oe,
  input wire logic regulator_enable
);
  logic [15:0] low_cnt;
  logic [3:0] cool_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // raw run of transmit low against a high, unheld bus; saturates on long faults
  always_ff @(posedge core_clk) begin
    if (reset || pins.tx_data || !pins.bus_line_level || !pins.fault_pin_in) begin
      low_cnt <= 16'h0;
    end else if (low_cnt != 16'hffff) begin
      low_cnt <= low_cnt + 16'h1;
    end
  end
  // cycles since overtemperature, so a thermal edge is not taken for a mismatch
  always_ff @(posedge core_clk) begin
    if (reset || pins.thermal_hot) begin
      cool_cnt <= 4'h0;
    end else if (cool_cnt != 4'hf) begin
      cool_cnt <= cool_cnt + 4'h1;
    end
  end
  property p_drv_off; !pins.fault_pin_in [*6] |-> !bus_line_oe; endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on with pin low");
  property p_hot_pin; pins.thermal_hot [*6] |-> fault_or_tx_enable_pin_oe; endproperty
  a_hot_pin: assert property (p_hot_pin) else $error("hot but pin released");
  property p_reg_pin; !regulator_enable |-> fault_or_tx_enable_pin_oe; endproperty
  a_reg_pin: assert property (p_reg_pin) else $error("regulator off, pin released");
  property p_reg_rst; $fell(regulator_enable) |-> supply_reset_n_oe; endproperty
  a_reg_rst: assert property (p_reg_rst) else $error("regulator off, reset released");
  property p_pd_rst; powerdown_req |=> supply_reset_n_oe && !regulator_enable; endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("powerdown without reset");
  property p_agree; (pins.tx_data && !pins.thermal_hot) [*8] ##0 regulator_enable |-> !fault_or_tx_enable_pin_oe;
  endproperty
  a_agree: assert property (p_agree) else $error("fault with tx high");
  // a mismatch edge needs the whole hold-off window behind it
  property p_window;
    $rose(fault_or_tx_enable_pin_oe) && regulator_enable && cool_cnt == 4'hf
      |-> low_cnt >= MISMATCH_CYC - 2 || $past(low_cnt, 6) >= MISMATCH_CYC - 2;
  endproperty
  a_window: assert property (p_window) else $error("mismatch before window");
  property p_short; (pins.overload && pins.vreg_below_3v5 && pins.vreg_below_2v5) [*6] |-> !regulator_enable;
  endproperty
  a_short: assert property (p_short) else $error("regulator on into short");
  property p_tx_idle; pins.tx_data [*6] |-> !bus_line_oe; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("bus driven with tx high");
  c_mm: cover property ($rose(fault_or_tx_enable_pin_oe) && regulator_enable);
  c_short: cover property ($fell(regulator_enable) && pins.overload);
  c_pd: cover property (powerdown_req ##1 supply_reset_n_oe);
endmodule
`default_nettype wire

// ===== bench/lfs_host_model.sv
// host side: transmit data and the open-drain fault / tx-enable pin
// assumes a pull-up on the pin and commands from the bench on core_clk
`timescale 1ns/100ps
`default_nettype none
module lfs_host_model (
  input wire logic core_clk,
  input wire logic tx_cmd,
  input wire logic off_cmd,
  input wire logic fault_oe,
  output logic tx_data,
  output logic pin_level,
  output logic [7:0] faults_seen
);
  logic tx_q = 1'b1;
  logic [7:0] tick = 8'h0;
  logic [7:0] seen_q = 8'h0;
  assign tx_data = tx_q;
  assign faults_seen = seen_q;
  assign pin_level = !(fault_oe || off_cmd);
  // transmit changes just after the edge, as a uart shifter would
  always_ff @(posedge core_clk) tx_q <= tx_cmd;
  always_ff @(posedge core_clk) begin
    tick <= (tick == 8'hc7) ? 8'h0 : tick + 8'h1;
    if (tick == 8'h0 && !pin_level && !off_cmd) begin
      seen_q <= seen_q + 8'h1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_lfs_supervisor.sv
// bench for the fault pin and supply supervisor
// assumes design, checker and host model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_lfs_supervisor;
  import lfs_pkg::*;
  localparam int M = 20;
  localparam int R = 50;
  localparam int W = 9;
  logic core_clk, reset, powerdown_req, reg_wr, reg_rd, reg_en, rx_data, bus_oe, flt_oe, rst_oe;
  logic tx_cmd, off_cmd, short_bat, node_dom, tx_data, pin_lvl, bus_lvl;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] seen;
  logic bus_out, flt_out, rst_out;
  lfs_pins_t pv, pins;
  int err_count, check_count, cyc;
  lfs_supervisor #(.MISMATCH_CYC(M), .RETRY_CYC(R)) dut (
    .core_clk, .reset, .pins, .powerdown_req, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_line_out(bus_out), .bus_line_oe(bus_oe), .rx_data, .fault_or_tx_enable_pin_out(flt_out),
    .fault_or_tx_enable_pin_oe(flt_oe), .supply_reset_n_out(rst_out), .supply_reset_n_oe(rst_oe),
    .regulator_enable(reg_en));
  lfs_host_model host (.core_clk, .tx_cmd, .off_cmd, .fault_oe(flt_oe), .tx_data, .pin_level(pin_lvl),
    .faults_seen(seen));
  // bus: pull-up, our driver, another node, or a short to battery
  assign bus_lvl = short_bat || !(bus_oe || node_dom);
  always_comb begin
    pins = pv;
    pins.tx_data = tx_data;
    pins.bus_line_level = bus_lvl;
    pins.fault_pin_in = pin_lvl;
  end
  always #5 core_clk = ~core_clk;
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // waits end on an edge, so checks see the settled pre-edge values
  task automatic cyc_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m, input string s);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk(s, e, reg_rdata & m);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    core_clk = 0; reset = 1; pv = '0; powerdown_req = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0;
    reg_rd = 0; tx_cmd = 1; off_cmd = 0; short_bat = 0; node_dom = 0; err_count = 0; check_count = 0; cyc = 0;
    cyc_n(12);
    chk("flt_rst", 1, flt_oe);
    chk("rst_rst", 1, rst_oe);
    reset <= 0;
    cyc_n(W);
    chk("reg_nobat", 0, reg_en);
    chk("rst_nobat", 1, rst_oe);
    chk("flt_nobat", 1, flt_oe);
    rd(4'h0, 0, 32'h3, "ctrl_rst");
    wr(4'hc, '1);
    rd(4'hc, 0, '1, "unmapped");
    pv.vbb_above_6v0 <= 1; pv.vbb_above_5v75 <= 1;
    cyc_n(W);
    chk("reg_on", 1, reg_en);
    chk("rst_off", 0, rst_oe);
    chk("flt_off", 0, flt_oe);
    chk("od_out", 0, {bus_out, flt_out, rst_out});
    tx_cmd <= 0;
    cyc_n(W);
    chk("bus_dom", 1, bus_oe);
    // the receive path needs one full round trip through the bus before rx follows
    cyc_n(M + 5);
    chk("rx_lo", 0, rx_data);
    chk("agree_lo", 0, flt_oe);
    tx_cmd <= 1; node_dom <= 1;
    cyc_n(M + W);
    chk("rx_node", 0, rx_data);
    chk("recv", 0, flt_oe);
    node_dom <= 0; short_bat <= 1; tx_cmd <= 0;
    cyc_n(M + 3);
    chk("early", 0, flt_oe);
    cyc_n(W + 2);
    chk("mismatch", 1, flt_oe);
    chk("drv_off", 0, bus_oe);
    rd(4'h4, 32'h105, '1, "st_mm");
    cyc_n(200);
    chk("host_saw", 1, seen != 0);
    rd(4'h8, 1, 1, "ev_mm");
    tx_cmd <= 1;
    cyc_n(W);
    chk("mm_clr", 0, flt_oe);
    wr(4'h8, 32'h1);
    rd(4'h8, 0, 1, "ev_clr");
    off_cmd <= 1; tx_cmd <= 0;
    cyc_n(M + W + 4);
    chk("off_drv", 0, bus_oe);
    chk("off_flt", 0, flt_oe);
    rd(4'h4, 8, 8, "st_off");
    rd(4'h8, 0, 1, "off_ev");
    off_cmd <= 0; tx_cmd <= 1; short_bat <= 0; pv.thermal_hot <= 1;
    cyc_n(W);
    chk("hot_flt", 1, flt_oe);
    chk("hot_reg", 0, reg_en);
    rd(4'h8, 8, 8, "ev_hot");
    pv.thermal_hot <= 0;
    cyc_n(W);
    chk("cool_reg", 1, reg_en);
    pv.overload <= 1; pv.vreg_below_3v5 <= 1;
    cyc_n(W);
    chk("sc_reg", 0, reg_en);
    chk("sc_rst", 1, rst_oe);
    pv.overload <= 0; pv.vreg_below_3v5 <= 0;
    cyc_n(R - W - 2);
    chk("sc_wait", 0, reg_en);
    cyc_n(W + 4);
    chk("sc_back", 1, reg_en);
    wr(4'h0, 32'h1);
    rd(4'h0, 1, 32'h3, "ctrl_wr");
    pv.overload <= 1; pv.vreg_below_3v5 <= 1;
    cyc_n(W);
    chk("lv_hold", 1, reg_en);
    pv.vreg_below_2v5 <= 1;
    cyc_n(W);
    chk("lv_trip", 0, reg_en);
    pv.overload <= 0; pv.vreg_below_3v5 <= 0; pv.vreg_below_2v5 <= 0;
    wr(4'h0, 32'h0);
    cyc_n(R + W + 4);
    pv.vbb_above_6v0 <= 0; pv.vbb_above_5v75 <= 0; pv.track_below_3v5 <= 1; pv.track_below_4v25 <= 1;
    cyc_n(W);
    chk("uv_off", 0, reg_en);
    pv.track_below_3v5 <= 0; pv.track_below_4v25 <= 0; pv.vbb_above_5v75 <= 1;
    cyc_n(W);
    chk("uv_5v75", 0, reg_en);
    pv.vbb_above_6v0 <= 1;
    cyc_n(W);
    chk("uv_6v0", 1, reg_en);
    rd(4'h8, 32'h6, 32'h6, "ev_sc_uv");
    wr(4'h0, 32'h2);
    pv.vbb_above_6v0 <= 0; pv.vbb_above_5v75 <= 0; pv.track_below_4v25 <= 1;
    cyc_n(W);
    chk("alt_off", 0, reg_en);
    pv.track_below_4v25 <= 0; pv.vbb_above_5v75 <= 1;
    cyc_n(W);
    chk("alt_on", 1, reg_en);
    pv.vbb_above_6v0 <= 1;
    wr(4'h0, 32'h0);
    powerdown_req <= 1;
    cyc_n(2);
    chk("pd_rst", 1, rst_oe);
    chk("pd_reg", 0, reg_en);
    rd(4'h4, 32'h10, 32'h10, "st_pd");
    powerdown_req <= 0;
    cyc_n(W);
    chk("pd_back", 1, reg_en);
    reset <= 1;
    cyc_n(3);
    chk("rst2_flt", 1, flt_oe);
    reset <= 0;
    cyc_n(W);
    chk("rst2_reg", 1, reg_en);
    finish_test();
  end
endmodule
bind lfs_supervisor lfs_supervisor_asserts #(.MISMATCH_CYC(MISMATCH_CYC), .RETRY_CYC(RETRY_CYC)) u_chk (
  .core_clk, .reset, .pins, .powerdown_req, .bus_line_oe, .fault_or_tx_enable_pin_oe, .supply_reset_n_oe,
  .regulator_enable);
`default_nettype wire
